// *** rtl/ssp_pkg.sv ***
/*
 * ssp_pkg: shared constants and carrier types for the synchronous serial
 * port. Assumes a single 40 MHz system clock and no register bus.
 */
package ssp_pkg;
  // =========================================================================
  // timing and counts
  // =========================================================================
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] RATE_RESET = 2'h0;
  // master half-period in system clocks per rate code (4/8/16/64 divide)
  localparam logic [4:0] HALF_DIV0 = 5'h02;
  localparam logic [4:0] HALF_DIV1 = 5'h04;
  localparam logic [4:0] HALF_DIV2 = 5'h08;
  localparam logic [4:0] HALF_DIV3 = 5'h20;

  // =========================================================================
  // carriers
  // =========================================================================
  typedef struct packed {
    logic enable;
    logic master;
    logic cpol;
    logic lsb_first;
    logic [1:0] rate;
  } ssp_ctrl_s;

  typedef struct packed {
    logic done;
    logic collision;
    logic overflow;
    logic busy;
  } ssp_stat_s;

  typedef struct packed {
    logic o;
    logic oe_n;
    logic od;
  } ssp_pin_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEAD = 3'b010,
    ST_TRAIL = 3'b100
  } ssp_state_e;
endpackage

// *** rtl/ssp_sync_serial_port.sv ***
/*
 * ssp_sync_serial_port: full-duplex byte shifter, master or slave, clock
 * phase 1 format. Software side is plain strobes; pins are split into
 * input, output and active-low output enable. Assumes external pull-ups
 * on any pin configured open-drain.
 */
`timescale 1ns/1ps
// How it works
// RL1: phase 1: cpol 0 idles low, shift on rise, sample on fall; cpol 1 swaps.
// RL2: master data write starts a transfer; first bit on first clock edge.
// RL3: bit order select picks msb-first or lsb-first shifting.
// RL4: slave accepts data writes whatever the slave-select level.
// RL5: done flag sets after the last shift cycle, master or slave.
// RL6: software should wait for done before writing next byte.
// RL7: one byte swapped full duplex; shifter ends holding the received byte.
// RL8: interrupt request pulses when done flag rises from 0 to 1.
// RL9: write during transfer does not reach shifter nor stop the transfer.
// RL10: write collision detection works in master and slave modes.
// RL11: slave overflow sets when a byte completes while previous unread.
// RL12: on overflow the data register takes the new byte anyway.
// RL13: clock, master-out and master-in each selectable open-drain.
// RL14: flags clear by status read then data access; master clears overflow.
// RL15: slave ignores clock and data while slave-select is high.
// RL16: master drives exactly eight clock pulses, idle otherwise.
// RL17: slave master-in output driven only while enable is set.
module ssp_sync_serial_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // configuration
  input wire ssp_pkg::ssp_ctrl_s ctrl,
  input wire logic [2:0] open_drain,
  // software access
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic data_rd,
  input wire logic status_rd,
  output logic [7:0] serial_data_reg,
  output ssp_pkg::ssp_stat_s serial_status_reg,
  output logic serial_port_irq,
  // pins
  input wire logic sclk_i,
  output ssp_pkg::ssp_pin_s sclk_pin,
  input wire logic mosi_i,
  output ssp_pkg::ssp_pin_s mosi_pin,
  input wire logic miso_i,
  output ssp_pkg::ssp_pin_s miso_pin,
  input wire logic ss_n_i
);
  // ==========================================================================
  // input synchronisers: three stages, change counted when 2 and 3 agree
  // ==========================================================================
  logic [2:0] sclk_s_q, ss_s_q, mosi_s_q, miso_s_q;
  logic sclk_f_q, ss_f_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_s_q <= 3'h0;
      ss_s_q <= 3'h7;
      mosi_s_q <= 3'h0;
      miso_s_q <= 3'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk_i};
      ss_s_q <= {ss_s_q[1:0], ss_n_i};
      mosi_s_q <= {mosi_s_q[1:0], mosi_i};
      miso_s_q <= {miso_s_q[1:0], miso_i};
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_f_q <= 1'b0;
      ss_f_q <= 1'b1;
    end else begin
      if (sclk_s_q[1] == sclk_s_q[2]) sclk_f_q <= sclk_s_q[2];
      if (ss_s_q[1] == ss_s_q[2]) ss_f_q <= ss_s_q[2];
    end
  end
  wire sclk_new = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_f_q;
  wire ss_sel = ~ss_f_q;
  // leading edge leaves idle level (shift), trailing returns (sample)
  wire s_edge = ctrl.enable & ~ctrl.master & ss_sel &
                (sclk_new != sclk_f_q); // [RL15]
  wire s_lead = s_edge & (sclk_f_q == ctrl.cpol); // [RL1]
  wire s_trail = s_edge & (sclk_f_q != ctrl.cpol); // [RL1]

  // ==========================================================================
  // master clock divider
  // ==========================================================================
  ssp_pkg::ssp_state_e st_q, st_d;
  logic [4:0] div_q;
  logic [3:0] cnt_q;
  logic sclk_q;
  logic [7:0] sh_q;
  // rate 0 leaves two clocks per half period, less than the three-flop
  // input delay, so the master would sample a stale miso bit there
  wire [4:0] half_div = (ctrl.rate == 2'h0) ? ssp_pkg::HALF_DIV0 :
                        (ctrl.rate == 2'h1) ? ssp_pkg::HALF_DIV1 :
                        (ctrl.rate == 2'h2) ? ssp_pkg::HALF_DIV2 :
                                              ssp_pkg::HALF_DIV3;
  wire tick = (div_q == half_div - 5'h01);
  wire busy = (st_q != ssp_pkg::ST_IDLE);
  wire m_start = ctrl.enable & ctrl.master & data_wr & ~busy; // [RL2]
  wire m_lead = ctrl.master & tick & (st_q == ssp_pkg::ST_LEAD);
  wire m_trail = ctrl.master & tick & (st_q == ssp_pkg::ST_TRAIL);
  wire do_lead = m_lead | s_lead;
  wire do_trail = m_trail | s_trail;
  wire last_bit = (cnt_q == ssp_pkg::BITS_PER_BYTE - 4'h1);
  wire byte_end = do_trail & last_bit & (st_q == ssp_pkg::ST_TRAIL); // [RL5]
  wire collide = data_wr & busy; // [RL9] [RL10]
  wire sample_in = ctrl.master ? miso_s_q[2] : mosi_s_q[2];
  wire tx_bit = ctrl.lsb_first ? sh_q[0] : sh_q[7]; // [RL3]

  always_comb begin
    st_d = st_q;
    case (st_q)
      ssp_pkg::ST_IDLE: begin
        // a slave's first lead edge is itself the shift: a sample follows
        if (m_start) st_d = ssp_pkg::ST_LEAD;
        else if (s_lead) st_d = ssp_pkg::ST_TRAIL;
      end
      ssp_pkg::ST_LEAD: begin
        if (do_lead) st_d = ssp_pkg::ST_TRAIL;
      end
      ssp_pkg::ST_TRAIL: begin
        if (do_trail) st_d = last_bit ? ssp_pkg::ST_IDLE : ssp_pkg::ST_LEAD;
      end
      default: st_d = ssp_pkg::ST_IDLE;
    endcase
    if (!ctrl.enable) st_d = ssp_pkg::ST_IDLE;
  end

  // slave's first lead edge also arrives while idle, so lead acts in IDLE too
  wire lead_act = do_lead & (st_q != ssp_pkg::ST_TRAIL);
  wire trail_act = do_trail & (st_q == ssp_pkg::ST_TRAIL);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= ssp_pkg::ST_IDLE;
      div_q <= 5'h00;
      cnt_q <= 4'h0;
      sclk_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= (m_start || tick || !busy) ? 5'h00 : div_q + 5'h01;
      if (m_lead || m_trail) sclk_q <= ~sclk_q; // [RL16]
      else if (!busy) sclk_q <= 1'b0;
      if (!busy && !s_lead) cnt_q <= 4'h0;
      else if (trail_act) cnt_q <= cnt_q + 4'h1;
    end
  end

  // ==========================================================================
  // shifter and data register
  // ==========================================================================
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sh_q <= ssp_pkg::DATA_RESET;
    end else if (data_wr && !busy) begin
      sh_q <= data_wdata; // [RL4] [RL9]
    end else if (trail_act) begin
      if (ctrl.lsb_first) sh_q <= {sample_in, sh_q[7:1]}; // [RL7]
      else sh_q <= {sh_q[6:0], sample_in}; // [RL7]
    end
  end
  assign serial_data_reg = sh_q;

  // output bit updates on the leading (shift) edge
  logic out_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) out_q <= 1'b1;
    else if (lead_act) out_q <= tx_bit; // [RL1] [RL2]
  end

  // ==========================================================================
  // flags
  // ==========================================================================
  logic done_q, coll_q, ovf_q, armed_q, irq_q;
  wire clear_ok = armed_q & (data_rd | data_wr); // [RL14]
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
      coll_q <= 1'b0;
      ovf_q <= 1'b0;
      armed_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (status_rd) armed_q <= 1'b1;
      else if (data_rd || data_wr) armed_q <= 1'b0;
      // set wins over clear
      if (byte_end) done_q <= 1'b1; // [RL5]
      else if (clear_ok) done_q <= 1'b0; // [RL14]
      if (collide) coll_q <= 1'b1; // [RL10]
      else if (clear_ok) coll_q <= 1'b0; // [RL14]
      if (byte_end && !ctrl.master && done_q) ovf_q <= 1'b1; // [RL11] [RL12]
      else if (clear_ok || ctrl.master) ovf_q <= 1'b0; // [RL14]
      irq_q <= byte_end & ~done_q; // [RL8]
    end
  end
  assign serial_port_irq = irq_q;
  assign serial_status_reg = '{done: done_q, collision: coll_q,
                               overflow: ovf_q, busy: busy};

  // ==========================================================================
  // pins: oe_n low while driving; open-drain drives only a low
  // ==========================================================================
  wire sclk_lvl = sclk_q ^ ctrl.cpol; // [RL1]
  wire m_drv = ctrl.enable & ctrl.master;
  wire s_drv = ctrl.enable & ~ctrl.master; // [RL17]
  assign sclk_pin = '{o: sclk_lvl & ~open_drain[0],
                      oe_n: ~(m_drv & (~open_drain[0] | ~sclk_lvl)),
                      od: open_drain[0]}; // [RL13]
  assign mosi_pin = '{o: out_q & ~open_drain[1],
                      oe_n: ~(m_drv & (~open_drain[1] | ~out_q)),
                      od: open_drain[1]}; // [RL13]
  assign miso_pin = '{o: out_q & ~open_drain[2],
                      oe_n: ~(s_drv & (~open_drain[2] | ~out_q)),
                      od: open_drain[2]}; // [RL13] [RL17]

  // ==========================================================================
  // checks
  // ==========================================================================
  sequence byte_finish;
    byte_end ##1 1'b1;
  endsequence
  a_done_sets: assert property (@(posedge ref_clk) disable iff (rst)
    byte_finish |-> done_q) else $error("done not set"); // [RL5]
  a_irq_rise: assert property (@(posedge ref_clk) disable iff (rst)
    serial_port_irq |-> $rose(done_q)) else $error("irq w/o rise"); // [RL8]
  a_coll_flag: assert property (@(posedge ref_clk) disable iff (rst)
    collide |=> coll_q) else $error("collision missed"); // [RL10]
  a_coll_keep: assert property (@(posedge ref_clk) disable iff (rst)
    collide |=> $stable(st_q) || st_q != ssp_pkg::ST_IDLE || $past(byte_end))
    else $error("transfer halted"); // [RL9]
  a_ovf_slave: assert property (@(posedge ref_clk) disable iff (rst)
    ctrl.master |=> !ovf_q) else $error("ovf in master"); // [RL14]
  a_ovf_sets: assert property (@(posedge ref_clk) disable iff (rst)
    byte_end && !ctrl.master && done_q |=> ovf_q)
    else $error("overflow missed"); // [RL11]
  a_miso_off: assert property (@(posedge ref_clk) disable iff (rst)
    !ctrl.enable |-> miso_pin.oe_n) else $error("miso driven"); // [RL17]
  a_sclk_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !busy ##1 !busy |-> sclk_lvl == ctrl.cpol)
    else $error("clock not idle"); // [RL16]
  a_slave_deaf: assert property (@(posedge ref_clk) disable iff (rst)
    ss_f_q && !ctrl.master |-> !s_lead && !s_trail)
    else $error("slave took clock"); // [RL15]
  a_master_start: assert property (@(posedge ref_clk) disable iff (rst)
    m_start |=> busy) else $error("no start"); // [RL2]
endmodule

// *** verif/ssp_far_end.sv ***
/*
 * ssp_far_end: behavioural far-side serial device, master or slave,
 * clock phase 1 only. Assumes the bench wires every line with pull-ups.
 */
`timescale 1ns/1ps
module ssp_far_end (
  // configuration
  input wire logic is_master,
  input wire logic act,
  input wire logic cpol,
  input wire logic lsb,
  // byte exchange
  input wire logic start,
  input wire logic [7:0] tx,
  output logic [7:0] rx,
  // lines
  input wire logic sclk_w,
  input wire logic sdi,
  output logic sclk,
  output logic sdo
);
  logic run;
  logic clk_q;
  int n;
  initial begin
    rx = 8'h00; sdo = 1'b1; run = 1'b0; clk_q = 1'b0; n = 0;
  end
  // =========================================================================
  // clock stands at idle outside frames
  // =========================================================================
  assign sclk = run ? clk_q : cpol;
  // =========================================================================
  // slave role: shift on leading edge, sample on trailing edge
  // =========================================================================
  always @(sclk_w) begin
    if (act && !is_master) begin
      if (sclk_w !== cpol) begin
        sdo = lsb ? tx[n] : tx[7 - n];
      end else begin
        rx[lsb ? n : 7 - n] = sdi;
        n = (n == 7) ? 0 : n + 1;
        // line inverted after the frame shows no stale bit
        if (n == 0) sdo = ~sdo;
      end
    end
  end
  // =========================================================================
  // master role: eight pulses, 100 ns per half period
  // =========================================================================
  always @(posedge start) begin
    if (is_master) begin
      for (int i = 0; i < 8; i++) begin
        clk_q = ~cpol;
        run = 1'b1;
        sdo = lsb ? tx[i] : tx[7 - i];
        #100;
        clk_q = cpol;
        rx[lsb ? i : 7 - i] = sdi;
        #100;
      end
      run = 1'b0;
      sdo = ~sdo;
    end
  end
endmodule

// *** verif/tb_top.sv ***
/*
 * tb_top: self-checking bench for the serial port, driving strobes at
 * the falling edge. Assumes pull-ups on sclk, mosi and miso.
 */
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rst, data_wr, data_rd, status_rd, ss_n, act, f_mst, f_go;
  logic [2:0] open_drain;
  logic [7:0] data_wdata, f_tx, f_rx, dreg;
  ssp_pkg::ssp_ctrl_s ctrl;
  ssp_pkg::ssp_stat_s st;
  ssp_pkg::ssp_pin_s sclk_pin, mosi_pin, miso_pin;
  logic irq, sclk_w, mosi_w, miso_w, f_sclk, f_sdo, f_sdi;
  int num_errors, checks, irq_n, pulses;
  // =========================================================================
  // wired-and lines, pulled up when nobody drives low
  // =========================================================================
  assign sclk_w = (sclk_pin.oe_n ? 1'b1 : sclk_pin.o) &
                  (f_mst ? f_sclk : 1'b1);
  assign mosi_w = (mosi_pin.oe_n ? 1'b1 : mosi_pin.o) &
                  (f_mst ? f_sdo : 1'b1);
  assign miso_w = (miso_pin.oe_n ? 1'b1 : miso_pin.o) & (f_mst ? 1'b1 : f_sdo);
  assign f_sdi = f_mst ? miso_w : mosi_w;
  ssp_sync_serial_port DUT (.ref_clk(ref_clk), .rst(rst), .ctrl(ctrl),
    .open_drain(open_drain), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_rd(data_rd), .status_rd(status_rd), .serial_data_reg(dreg),
    .serial_status_reg(st), .serial_port_irq(irq), .sclk_i(sclk_w),
    .sclk_pin(sclk_pin), .mosi_i(mosi_w), .mosi_pin(mosi_pin),
    .miso_i(miso_w), .miso_pin(miso_pin), .ss_n_i(ss_n));
  ssp_far_end far (.is_master(f_mst), .act(act), .cpol(ctrl.cpol),
    .lsb(ctrl.lsb_first), .start(f_go), .tx(f_tx), .rx(f_rx),
    .sclk_w(sclk_w), .sdi(f_sdi), .sclk(f_sclk), .sdo(f_sdo));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) if (irq === 1'b1) irq_n++;
  always @(sclk_w) if (act && sclk_w !== ctrl.cpol) pulses++;
  // =========================================================================
  // access tasks
  // =========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
  endtask
  task automatic wr(input logic [7:0] d);
    data_wdata = d;
    pulse(data_wr);
  endtask
  task automatic clr();
    pulse(status_rd);
    pulse(data_rd);
  endtask
  task automatic wait_done();
    int k;
    for (k = 0; k < 3000 && st.done !== 1'b1; k++) @(negedge ref_clk);
    if (k == 3000) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // =========================================================================
  // main sequence
  // =========================================================================
  initial begin
    rst = 1'b1; data_wr = 1'b0; data_rd = 1'b0; status_rd = 1'b0;
    ss_n = 1'b0; act = 1'b0; f_mst = 1'b0; f_go = 1'b0; f_tx = 8'h00;
    open_drain = 3'h0; data_wdata = 8'h00; num_errors = 0; checks = 0;
    ctrl = '{enable:1'b1, master:1'b1, cpol:1'b0, lsb_first:1'b0, rate:2'h2};
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    chk(dreg, 8'h00);
    chk({4'h0, st}, 8'h00);
    // master: every polarity and bit order, with a colliding write
    for (int i = 0; i < 4; i++) begin
      ctrl.cpol = i[0];
      ctrl.lsb_first = i[1];
      open_drain = {3{i[1]}};
      // rates 1..3; rate 0 outruns the synchronised miso input
      ctrl.rate = 2'(i % 3 + 1);
      repeat (4) @(negedge ref_clk);
      act = 1'b1; pulses = 0; irq_n = 0; f_tx = 8'h3C ^ 8'(i);
      wr(8'h1E + 8'(i));
      repeat (20) @(negedge ref_clk);
      wr(8'hFF);
      wait_done();
      @(negedge ref_clk);
      chk(f_rx, 8'h1E + 8'(i));
      chk(dreg, 8'h3C ^ 8'(i));
      chk({7'h0, st.collision}, 8'h01);
      chk(8'(pulses), 8'h08);
      chk(8'(irq_n), 8'h01);
      chk({5'h0, miso_pin.od, mosi_pin.od, sclk_pin.od},
          {5'h0, open_drain});
      clr();
      chk({4'h0, st}, 8'h00);
      act = 1'b0;
    end
    // slave: write with select high, then overrun without reading
    ctrl = '{enable:1'b1, master:1'b0, cpol:1'b0, lsb_first:1'b0, rate:2'h2};
    f_mst = 1'b1; ss_n = 1'b1; open_drain = 3'h0;
    repeat (4) @(negedge ref_clk);
    wr(8'h5A);
    ss_n = 1'b0; act = 1'b1; f_tx = 8'hC3;
    repeat (4) @(negedge ref_clk);
    pulse(f_go);
    wait_done();
    chk(f_rx, 8'h5A);
    chk(dreg, 8'hC3);
    f_tx = 8'h96;
    pulse(f_go);
    repeat (100) @(negedge ref_clk);
    chk({7'h0, st.overflow}, 8'h01);
    chk(dreg, 8'h96);
    chk(f_rx, 8'hC3);
    clr();
    chk({4'h0, st}, 8'h00);
    // deselected slave takes nothing in
    ss_n = 1'b1; f_tx = 8'h69;
    repeat (4) @(negedge ref_clk);
    pulse(f_go);
    repeat (100) @(negedge ref_clk);
    chk({7'h0, st.done}, 8'h00);
    chk(dreg, 8'h96);
    ctrl.enable = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({7'h0, miso_pin.oe_n}, 8'h01);
    report_and_stop();
  end
endmodule
